// file: bol_chk.sv
`timescale 1ns/1ps
module bol_chk #(
    parameter int NUM_GPO = bol_pkg::NUM_GPO,
    parameter int NUM_GPI = bol_pkg::NUM_GPI,
    parameter int NUM_RAIL = bol_pkg::NUM_RAIL
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic [NUM_GPI-1:0] gpi_pin,
    input wire logic [NUM_GPI-1:0] gpi_active_high,
    input wire logic [NUM_RAIL-1:0] rail_margin_cfg,
    input wire logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] rail_flags,
    input wire logic vendor_clear_cmd,
    input wire logic fault_pin_en,
    input wire logic [bol_pkg::SEL_W-1:0] fault_pin_sel,
    input wire logic mrg_en_pin_en,
    input wire logic [bol_pkg::SEL_W-1:0] mrg_en_pin_sel,
    input wire logic mrg_dir_pin_en,
    input wire logic [bol_pkg::SEL_W-1:0] mrg_dir_pin_sel,
    input wire logic [NUM_GPO-1:0] out_active_high,
    input wire logic [NUM_GPO-1:0] open_drain,
    input wire logic [NUM_GPO-1:0] cmd_mode,
    input wire logic [NUM_GPO-1:0] cmd_value,
    // Watched outputs
    input wire logic [NUM_GPO-1:0] gpo_pin_o,
    input wire logic [NUM_GPO-1:0] gpo_pin_oe_n,
    input wire logic [bol_pkg::NUM_FB-1:0] gpo_dep_state,
    input wire logic gpi_fault,
    input wire logic [NUM_RAIL-1:0] rail_margin_active,
    input wire logic [NUM_RAIL-1:0] rail_margin_low,
    input wire logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] latched_flags
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    logic [NUM_GPI-1:0] pa;
    logic [NUM_GPI-1:0] p1_q;
    logic [NUM_GPI-1:0] p2_q;
    logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] src;
    logic [2:0] up_d;
    logic [2:0] up_q;
    assign pa = ~(p2_q ^ gpi_active_high);
    always_comb begin
        up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
        for (int t = 0; t < bol_pkg::NUM_LIVE; t++) begin
            src[t] = rail_flags[bol_pkg::LATCH_SRC[t]];
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 3'h0;
            p1_q <= '0;
            p2_q <= '0;
        end else begin
            up_q <= up_d;
            p1_q <= gpi_pin;
            p2_q <= p1_q;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_LATCH_SET: assert property (rail_flags != '0 |=>
        (latched_flags & $past(src)) == $past(src)) else $error("latch not set");
    AST_LATCH_HOLD: assert property ((!vendor_clear_cmd && $stable(gpi_pin)
        && $stable(gpi_active_high)) [*5] |=>
        (latched_flags & $past(latched_flags)) == $past(latched_flags)) else $error("latch lost");
    AST_VENDOR_CLR: assert property (vendor_clear_cmd && rail_flags == '0 |=>
        latched_flags == '0) else $error("latch not cleared");
    AST_FAULT: assert property (up_q == 3'h7 |->
        gpi_fault == $past(fault_pin_en && !pa[fault_pin_sel])) else $error("fault wrong");
    AST_MRG_ACT: assert property (up_q == 3'h7 |-> rail_margin_active ==
        ($past(mrg_en_pin_en && pa[mrg_en_pin_sel]) ? $past(rail_margin_cfg) : '0))
        else $error("margin enable wrong");
    AST_MRG_LOW: assert property (up_q == 3'h7 |-> rail_margin_low ==
        ($past(mrg_dir_pin_en && pa[mrg_dir_pin_sel]) ? rail_margin_active : '0))
        else $error("margin direction wrong");
    AST_DEP_TICK: assert property ($changed(gpo_dep_state) |=>
        $stable(gpo_dep_state) [*8]) else $error("result changed off tick");
    AST_OD: assert property (up_q == 3'h7 && $stable(open_drain) |->
        ((~gpo_pin_oe_n) & open_drain & gpo_pin_o) == '0) else $error("open drain drove high");
    AST_PP: assert property (up_q == 3'h7 && $stable(open_drain) |->
        ((~open_drain) & gpo_pin_oe_n) == '0) else $error("push pull released");
    AST_CMD: assert property (up_q == 3'h7 && $stable(cmd_mode) && $stable(cmd_value)
        && $stable(out_active_high) && $stable(open_drain) |=> (((gpo_pin_o ^ $past(gpo_pin_o))
        | (gpo_pin_oe_n ^ $past(gpo_pin_oe_n))) & $past(cmd_mode)) == '0)
        else $error("command pin moved");
endmodule
bind bol_top bol_chk #(.NUM_GPO(NUM_GPO), .NUM_GPI(NUM_GPI), .NUM_RAIL(NUM_RAIL)) i_bol_chk (.*);

// file: bol_delay.sv
`timescale 1ns/1ps
module bol_delay (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Timebase and logic result
    input wire logic tick,
    input wire logic logic_in,
    // Configuration
    input wire logic [bol_pkg::DLY_W-1:0] dly_ticks,
    input wire logic dly_assert,
    input wire logic dly_deassert,
    input wire logic ignore_inputs,
    // Filtered result
    output logic out_q
);
    bol_pkg::bol_dly_state_t state_q;
    bol_pkg::bol_dly_state_t state_d;
    logic [bol_pkg::DLY_W-1:0] cnt_q;
    logic [bol_pkg::DLY_W-1:0] cnt_d;
    logic out_d;
    logic use_dly;

    // ****************************************************************
    // Delay filter
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        out_d = out_q;
        // Ignore mode holds both edges for the delay so no output pulse is shorter than the delay
        use_dly = ((logic_in ? dly_assert : dly_deassert) || ignore_inputs)
            && (dly_ticks != '0);
        if (tick) begin
            unique case (state_q)
                bol_pkg::DLY_IDLE: begin
                    if (logic_in != out_q) begin
                        if (use_dly) begin
                            state_d = bol_pkg::DLY_RUN;
                            cnt_d = dly_ticks - 1'b1;
                        end else begin
                            out_d = logic_in;
                        end
                    end
                end
                bol_pkg::DLY_RUN: begin
                    if (!ignore_inputs && (logic_in == out_q)) begin
                        state_d = bol_pkg::DLY_IDLE;
                    end else if (cnt_q == '0) begin
                        out_d = ~out_q;
                        state_d = bol_pkg::DLY_IDLE;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= bol_pkg::DLY_IDLE;
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end
endmodule

// file: bol_gpi_sync.sv
`timescale 1ns/1ps
module bol_gpi_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pins and polarity
    input wire logic [W-1:0] pin_i,
    input wire logic [W-1:0] active_high,
    // Asserted view
    output logic [W-1:0] asserted
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    // ****************************************************************
    // Two-stage synchroniser
    // ****************************************************************
    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    // Polarity applied after synchronisation
    assign asserted = ~(sync_q ^ active_high);
endmodule

// file: bol_pads_model.sv
`timescale 1ns/1ps
module bol_pads_model (
    // Driver side
    input wire logic [bol_pkg::NUM_GPO-1:0] gpo_pin_o,
    input wire logic [bol_pkg::NUM_GPO-1:0] gpo_pin_oe_n,
    // Board level with pull-ups
    output logic [bol_pkg::NUM_GPO-1:0] pad
);
    // Released pins float up
    assign pad = gpo_pin_o | gpo_pin_oe_n;
endmodule

// file: bol_pkg.sv
// Overview of operation
// - Each logic output outside state-machine mode is the OR of at most two AND terms.
// - Term inputs come from input pins, rail flags and the first eight outputs.
// - Each term picks one rail status type, then any subset of active rails.
// - Latched status types stay set until vendor clear command or clear pin.
// - Power good, margin, fault, warning, timeout types, with latched variants, selectable.
// - First eight logic results, not pin levels, serve as sequencing dependencies.
// - Power good feeds logic only for rails with voltage monitoring.
// - Delay applies on assertion, deassertion, both, or neither, per output.
// - Normal delay ignores a change that reverts before expiry: glitch filter.
// - Ignore mode: a change starts the delay, output changes at expiry regardless.
// - Ignore mode: every output pulse lasts at least the configured delay.
// - State-machine mode: true uses path 0, false uses path 1.
// - Each special input function has at most one assigned input pin.
// - With fault enable, deassertion of the selected pin is a fault.
// - Activation of the latch-clear pin clears the latched rail flags.
// - Margin-enable pin asserted puts every margining-enabled rail into margin.
// - Margin-direction pin asserted selects low, deasserted selects high.
// - Each input pin has configurable polarity deciding what counts as asserted.
// - First three defined input pins form the pin-selected rail state selector.
// - Each output pin is open-drain or push-pull.
// - Each output pin follows either the command value or the logic block.
package bol_pkg;
    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_GPO = 10;
    localparam int NUM_GPI = 8;
    localparam int NUM_RAIL = 10;
    localparam int NUM_FB = 8;
    localparam int SEL_W = 3;
    localparam int DLY_W = 16;
    localparam int NUM_LIVE = 14;
    localparam int NUM_PINSEL = 3;

    // ****************************************************************
    // Timebase
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 12;

    // ****************************************************************
    // Rail status types
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_POWER_GOOD = 5'h00,
        ST_MARGIN_EN = 5'h01,
        ST_MARGIN_DIR = 5'h02,
        ST_OV_FAULT = 5'h03,
        ST_OV_WARN = 5'h04,
        ST_UV_WARN = 5'h05,
        ST_UV_FAULT = 5'h06,
        ST_TON_FAULT = 5'h07,
        ST_TOFF_WARN = 5'h08,
        ST_OC_FAULT = 5'h09,
        ST_OC_WARN = 5'h0a,
        ST_UC_FAULT = 5'h0b,
        ST_OT_FAULT = 5'h0c,
        ST_OT_WARN = 5'h0d,
        ST_SEQ_ON_TO = 5'h0e,
        ST_SEQ_OFF_TO = 5'h0f,
        ST_WDOG_TO = 5'h10,
        ST_OV_FAULT_L = 5'h11,
        ST_OV_WARN_L = 5'h12,
        ST_UV_WARN_L = 5'h13,
        ST_UV_FAULT_L = 5'h14,
        ST_TON_FAULT_L = 5'h15,
        ST_TOFF_WARN_L = 5'h16,
        ST_SEQ_ON_TO_L = 5'h17,
        ST_SEQ_OFF_TO_L = 5'h18,
        ST_WDOG_TO_L = 5'h19,
        ST_OC_FAULT_L = 5'h1a,
        ST_OC_WARN_L = 5'h1b,
        ST_UC_FAULT_L = 5'h1c,
        ST_OT_FAULT_L = 5'h1d,
        ST_OT_WARN_L = 5'h1e
    } bol_stat_t;

    localparam logic [4:0] LIVE_BASE = 5'h03;
    localparam logic [4:0] LATCH_BASE = 5'h11;

    // Live source of each latched type, as an index into the live flags
    localparam logic [3:0] LATCH_SRC [NUM_LIVE] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb,
        4'hc, 4'hd, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha
    };

    // Delay unit states
    typedef enum logic [0:0] {
        DLY_IDLE = 1'b0,
        DLY_RUN = 1'b1
    } bol_dly_state_t;
endpackage

// file: bol_top.sv
`timescale 1ns/1ps
module bol_top #(
    parameter int NUM_GPO = bol_pkg::NUM_GPO,
    parameter int NUM_GPI = bol_pkg::NUM_GPI,
    parameter int NUM_RAIL = bol_pkg::NUM_RAIL
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Input pins
    input wire logic [NUM_GPI-1:0] gpi_pin,
    input wire logic [NUM_GPI-1:0] gpi_active_high,
    input wire logic [NUM_GPI-1:0] gpi_defined,
    // Rail status from sequencing and monitoring engines
    input wire logic [NUM_RAIL-1:0] rail_active,
    input wire logic [NUM_RAIL-1:0] rail_pg,
    input wire logic [NUM_RAIL-1:0] rail_has_vmon,
    input wire logic [NUM_RAIL-1:0] rail_margin_cfg,
    input wire logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] rail_flags,
    input wire logic vendor_clear_cmd,
    // Special input function selection
    input wire logic fault_pin_en,
    input wire logic [bol_pkg::SEL_W-1:0] fault_pin_sel,
    input wire logic clr_pin_en,
    input wire logic [bol_pkg::SEL_W-1:0] clr_pin_sel,
    input wire logic mrg_en_pin_en,
    input wire logic [bol_pkg::SEL_W-1:0] mrg_en_pin_sel,
    input wire logic mrg_dir_pin_en,
    input wire logic [bol_pkg::SEL_W-1:0] mrg_dir_pin_sel,
    // Term configuration, two terms per output
    input wire logic [NUM_GPO-1:0][1:0][4:0] term_type,
    input wire logic [NUM_GPO-1:0][1:0][NUM_RAIL-1:0] term_rail_mask,
    input wire logic [NUM_GPO-1:0][1:0][NUM_GPI-1:0] term_gpi_mask,
    input wire logic [NUM_GPO-1:0][1:0][bol_pkg::NUM_FB-1:0] term_gpo_mask,
    // Output configuration
    input wire logic [NUM_GPO-1:0] sm_mode,
    input wire logic [NUM_GPO-1:0][bol_pkg::DLY_W-1:0] dly_ticks,
    input wire logic [NUM_GPO-1:0] dly_assert,
    input wire logic [NUM_GPO-1:0] dly_deassert,
    input wire logic [NUM_GPO-1:0] ignore_inputs,
    input wire logic [NUM_GPO-1:0] out_active_high,
    input wire logic [NUM_GPO-1:0] open_drain,
    input wire logic [NUM_GPO-1:0] cmd_mode,
    input wire logic [NUM_GPO-1:0] cmd_value,
    // Output pins
    output logic [NUM_GPO-1:0] gpo_pin_o,
    output logic [NUM_GPO-1:0] gpo_pin_oe_n,
    // Status toward sequencing, fault and margin engines
    output logic [bol_pkg::NUM_FB-1:0] gpo_dep_state,
    output logic gpi_fault,
    output logic [NUM_RAIL-1:0] rail_margin_active,
    output logic [NUM_RAIL-1:0] rail_margin_low,
    output logic [bol_pkg::NUM_PINSEL-1:0] pin_sel_state,
    output logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] latched_flags
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam logic [bol_pkg::TICK_W-1:0] TICK_LAST =
        bol_pkg::TICK_W'(bol_pkg::TICK_CYC - 1);

    logic [NUM_GPI-1:0] gpi_asserted;
    logic [bol_pkg::TICK_W-1:0] tick_cnt_q;
    logic [bol_pkg::TICK_W-1:0] tick_cnt_d;
    logic tick;
    logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] latch_q;
    logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] latch_d;
    logic clr_prev_q;
    logic clr_prev_d;
    logic clr_now;
    logic clr_event;
    logic [NUM_GPO-1:0] result_q;
    logic [NUM_GPO-1:0] result_d;
    logic [NUM_GPO-1:0] filt;
    logic [NUM_GPO-1:0] pin_o_q;
    logic [NUM_GPO-1:0] pin_o_d;
    logic [NUM_GPO-1:0] pin_oe_n_q;
    logic [NUM_GPO-1:0] pin_oe_n_d;
    logic fault_q;
    logic fault_d;
    logic [NUM_RAIL-1:0] mrg_act_q;
    logic [NUM_RAIL-1:0] mrg_act_d;
    logic [NUM_RAIL-1:0] mrg_low_q;
    logic [NUM_RAIL-1:0] mrg_low_d;
    logic [bol_pkg::NUM_PINSEL-1:0] psel_q;
    logic [bol_pkg::NUM_PINSEL-1:0] psel_d;
    logic [1:0] psel_cnt;
    logic [NUM_RAIL-1:0] stat_vec;
    logic [NUM_GPO-1:0][1:0] term_val;
    logic mrg_en_now;
    logic mrg_dir_now;

    // Selected special pin, asserted sense; one index per function
    function automatic logic pin_pick(input logic en, input logic [bol_pkg::SEL_W-1:0] sel,
                                      input logic [NUM_GPI-1:0] asrt);
        return en && asrt[sel];
    endfunction

    // Flags of one status type across all rails
    function automatic logic [NUM_RAIL-1:0] stat_flags(
        input logic [4:0] typ,
        input logic [NUM_RAIL-1:0] pg,
        input logic [NUM_RAIL-1:0] m_act,
        input logic [NUM_RAIL-1:0] m_low,
        input logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] live,
        input logic [bol_pkg::NUM_LIVE-1:0][NUM_RAIL-1:0] lat);
        logic [NUM_RAIL-1:0] v;
        v = '0;
        if (typ == bol_pkg::ST_POWER_GOOD) begin
            v = pg;
        end else if (typ == bol_pkg::ST_MARGIN_EN) begin
            v = m_act;
        end else if (typ == bol_pkg::ST_MARGIN_DIR) begin
            v = m_low;
        end else if (typ < bol_pkg::LATCH_BASE) begin
            v = live[4'(typ - bol_pkg::LIVE_BASE)];
        end else if (typ <= bol_pkg::ST_OT_WARN_L) begin
            v = lat[4'(typ - bol_pkg::LATCH_BASE)];
        end
        return v;
    endfunction

    // ****************************************************************
    // Input pins
    // ****************************************************************
    bol_gpi_sync #(
        .W(NUM_GPI)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_i(gpi_pin),
        .active_high(gpi_active_high),
        .asserted(gpi_asserted)
    );

    // ****************************************************************
    // Timebase divider
    // ****************************************************************
    always_comb begin
        tick = (tick_cnt_q == TICK_LAST);
        tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // ****************************************************************
    // Special functions and latched flags
    // ****************************************************************
    always_comb begin
        clr_now = pin_pick(clr_pin_en, clr_pin_sel, gpi_asserted);
        clr_prev_d = clr_now;
        clr_event = (clr_now && !clr_prev_q) || vendor_clear_cmd;
        mrg_en_now = pin_pick(mrg_en_pin_en, mrg_en_pin_sel, gpi_asserted);
        mrg_dir_now = pin_pick(mrg_dir_pin_en, mrg_dir_pin_sel, gpi_asserted);
        mrg_act_d = mrg_en_now ? rail_margin_cfg : '0;
        mrg_low_d = (mrg_en_now && mrg_dir_now) ? rail_margin_cfg : '0;
        fault_d = fault_pin_en && !gpi_asserted[fault_pin_sel];
        psel_d = '0;
        psel_cnt = '0;
        for (int i = 0; i < NUM_GPI; i++) begin
            if (gpi_defined[i] && (psel_cnt < 2'(bol_pkg::NUM_PINSEL))) begin
                psel_d[psel_cnt] = gpi_asserted[i];
                psel_cnt = psel_cnt + 1'b1;
            end
        end
        for (int t = 0; t < bol_pkg::NUM_LIVE; t++) begin
            // A new flag wins over a clear in the same cycle
            latch_d[t] = (clr_event ? '0 : latch_q[t]) | rail_flags[bol_pkg::LATCH_SRC[t]];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_prev_q <= 1'b1;
            mrg_act_q <= '0;
            mrg_low_q <= '0;
            fault_q <= 1'b0;
            psel_q <= '0;
            latch_q <= '0;
        end else begin
            clr_prev_q <= clr_prev_d;
            mrg_act_q <= mrg_act_d;
            mrg_low_q <= mrg_low_d;
            fault_q <= fault_d;
            psel_q <= psel_d;
            latch_q <= latch_d;
        end
    end

    // ****************************************************************
    // Boolean evaluation
    // ****************************************************************
    always_comb begin
        result_d = result_q;
        stat_vec = '0;
        for (int g = 0; g < NUM_GPO; g++) begin
            for (int p = 0; p < 2; p++) begin
                stat_vec = stat_flags(term_type[g][p], rail_pg & rail_has_vmon,
                                      mrg_act_q, mrg_low_q, rail_flags, latch_q);
                // Term is true when every selected input is set, selected rails that are inactive being skipped; empty term is false
                term_val[g][p] = (|term_rail_mask[g][p] || |term_gpi_mask[g][p]
                                  || |term_gpo_mask[g][p])
                    && &(stat_vec | ~(term_rail_mask[g][p] & rail_active))
                    && &(gpi_asserted | ~term_gpi_mask[g][p])
                    && &(result_q[bol_pkg::NUM_FB-1:0] | ~term_gpo_mask[g][p]);
            end
            if (tick) begin
                if (sm_mode[g]) begin
                    result_d[g] = result_q[g] ? term_val[g][0] : term_val[g][1];
                end else begin
                    result_d[g] = term_val[g][0] | term_val[g][1];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= '0;
        end else begin
            result_q <= result_d;
        end
    end

    // ****************************************************************
    // Delay filters
    // ****************************************************************
    for (genvar g = 0; g < NUM_GPO; g++) begin : g_dly
        bol_delay u_dly (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .tick(tick),
            .logic_in(result_q[g]),
            .dly_ticks(dly_ticks[g]),
            .dly_assert(dly_assert[g]),
            .dly_deassert(dly_deassert[g]),
            .ignore_inputs(ignore_inputs[g]),
            .out_q(filt[g])
        );
    end

    // ****************************************************************
    // Output pins
    // ****************************************************************
    always_comb begin
        for (int g = 0; g < NUM_GPO; g++) begin
            logic lvl;
            lvl = cmd_mode[g] ? cmd_value[g] : filt[g];
            lvl = out_active_high[g] ? lvl : ~lvl;
            pin_o_d[g] = open_drain[g] ? 1'b0 : lvl;
            pin_oe_n_d[g] = open_drain[g] ? lvl : 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_o_q <= '0;
            pin_oe_n_q <= '1;
        end else begin
            pin_o_q <= pin_o_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    assign gpo_pin_o = pin_o_q;
    assign gpo_pin_oe_n = pin_oe_n_q;
    assign gpo_dep_state = result_q[bol_pkg::NUM_FB-1:0];
    assign gpi_fault = fault_q;
    assign rail_margin_active = mrg_act_q;
    assign rail_margin_low = mrg_low_q;
    assign pin_sel_state = psel_q;
    assign latched_flags = latch_q;
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tb_top;
    localparam int TC = bol_pkg::TICK_CYC;
    localparam int D = 2;
    typedef struct packed {
        logic [7:0] pin; logic [7:0] ah; logic flt; logic [2:0] sel;
        logic [9:0] act; logic [9:0] low;
    } bol_row_t;
    localparam bol_row_t ROWS [5] = '{
        '{8'h00, 8'h00, 1'b0, 3'h7, 10'h2a5, 10'h2a5}, '{8'h00, 8'hff, 1'b1, 3'h0, 10'h000, 10'h000},
        '{8'h06, 8'hff, 1'b1, 3'h3, 10'h2a5, 10'h2a5}, '{8'h12, 8'h0f, 1'b1, 3'h1, 10'h2a5, 10'h000},
        '{8'h15, 8'h11, 1'b0, 3'h5, 10'h2a5, 10'h000}};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] gpi_pin = 8'h00;
    logic [7:0] gpi_active_high = 8'h00;
    logic [9:0] rail_pg = 10'h000;
    logic [9:0] rail_has_vmon = 10'h000;
    logic [13:0][9:0] rail_flags = '0;
    logic vendor_clear_cmd = 1'b0;
    logic [9:0][1:0][4:0] term_type = '0;
    logic [9:0][1:0][9:0] term_rail_mask = '0;
    logic [9:0][1:0][7:0] term_gpo_mask = '0;
    logic [9:0][15:0] dly_ticks = '0;
    logic [9:0] ignore_inputs = '0, cmd_value = 10'h004, rail_active = 10'h3ff, sm_mode = '0;
    logic [9:0] rail_margin_cfg = 10'h2a5, dly_assert = 10'h001, dly_deassert = '0;
    logic [9:0] out_active_high = 10'h3ff, open_drain = 10'h008, cmd_mode = 10'h3fc;
    logic fault_pin_en = 1'b1, clr_pin_en = 1'b1, mrg_en_pin_en = 1'b1, mrg_dir_pin_en = 1'b1;
    logic [9:0][1:0][7:0] term_gpi_mask = '0;
    logic [9:0] gpo_pin_o, gpo_pin_oe_n, pad, rail_margin_active, rail_margin_low;
    logic [7:0] gpo_dep_state;
    logic gpi_fault, seen;
    logic [2:0] pin_sel_state;
    logic [13:0][9:0] latched_flags;
    logic [1:0] mon;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    assign mon = {gpo_pin_o[0], gpo_dep_state[0]};
    always #20 core_clk = ~core_clk;
    bol_top i_bol_top (.gpi_defined(8'hb6), .fault_pin_sel(3'h0), .clr_pin_sel(3'h3),
        .mrg_en_pin_sel(3'h1), .mrg_dir_pin_sel(3'h2), .*);
    bol_pads_model i_bol_pads_model (.gpo_pin_o(gpo_pin_o), .gpo_pin_oe_n(gpo_pin_oe_n),
        .pad(pad));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic wait_mon(input int b, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (mon[b] !== v && cnt < lim) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 70000) begin
            num_errors++;
            results();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        term_rail_mask[0][0] = 10'h001;
        term_gpo_mask[1][0] = 8'h01;
        dly_ticks[0] = 16'(D);
        step(6);
        `CHK(gpo_pin_oe_n, 10'h3ff)
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            gpi_pin = ROWS[i].pin;
            gpi_active_high = ROWS[i].ah;
            step(5);
            `CHK(gpi_fault, ROWS[i].flt)
            `CHK(pin_sel_state, ROWS[i].sel)
            `CHK(rail_margin_active, ROWS[i].act)
            `CHK(rail_margin_low, ROWS[i].low)
        end
        `CHK(gpo_pin_oe_n[3], 1'b0)
        `CHK(pad[3:2], 2'h1)
        cmd_value = 10'h00c;
        step(3);
        `CHK({gpo_pin_oe_n[3], pad[3]}, 2'h3)
        gpi_active_high = 8'hff;
        gpi_pin = 8'h00;
        rail_flags[3][2] = 1'b1;
        step(1);
        rail_flags[3][2] = 1'b0;
        step(4);
        `CHK(latched_flags[3][2], 1'b1)
        vendor_clear_cmd = 1'b1;
        step(1);
        vendor_clear_cmd = 1'b0;
        step(1);
        `CHK(latched_flags[3][2], 1'b0)
        rail_flags[3][2] = 1'b1;
        step(1);
        rail_flags[3][2] = 1'b0;
        gpi_pin = 8'h08;
        step(6);
        `CHK(latched_flags[3][2], 1'b0)
        rail_pg = 10'h001;
        step(2 * TC + 10);
        `CHK(gpo_dep_state[0], 1'b0)
        rail_has_vmon = 10'h001;
        wait_mon(0, 1'b1, 2 * TC, n);
        step(TC + 5);
        `CHK(gpo_dep_state[1:0], 2'h3)
        `CHK(gpo_pin_o[0], 1'b0)
        wait_mon(1, 1'b1, 2 * TC, n);
        n = n + TC + 5;
        `CHK((n >= (D + 1) * TC - 1 && n <= (D + 1) * TC + 3), 1'b1)
        rail_pg = 10'h000;
        wait_mon(1, 1'b0, 2 * TC + 3, n);
        `CHK(gpo_pin_o[0], 1'b0)
        rail_pg = 10'h001;
        wait_mon(0, 1'b1, TC + 5, n);
        rail_pg = 10'h000;
        seen = 1'b0;
        repeat (3 * TC) begin
            @(negedge core_clk);
            seen = seen | gpo_pin_o[0];
        end
        `CHK(seen, 1'b0)
        ignore_inputs = 10'h001;
        rail_pg = 10'h001;
        wait_mon(0, 1'b1, TC + 5, n);
        rail_pg = 10'h000;
        wait_mon(1, 1'b1, 4 * TC, n);
        `CHK(gpo_pin_o[0], 1'b1)
        wait_mon(1, 1'b0, 4 * TC, n);
        `CHK((n >= D * TC - 2 && gpo_pin_o[0] === 1'b0), 1'b1)
        sm_mode = 10'h001;
        rail_pg = 10'h001;
        step(2 * TC);
        `CHK(gpo_dep_state[0], 1'b0)
        results();
    end
endmodule
